// File: core/gpil_map.svh
`ifndef GPIL_MAP_SVH
`define GPIL_MAP_SVH

// ----------------------------------------------------------------
// Link timing
// ----------------------------------------------------------------
`define GPIL_MCLK_PERIOD_PS 50000
`define GPIL_REF_FREQ_MHZ 125
`define GPIL_REF_PERIOD_PS (1000000 / `GPIL_REF_FREQ_MHZ)
`define GPIL_TXC_DELAY_NS 2
`define GPIL_TXC_DELAY_PS (`GPIL_TXC_DELAY_NS * 1000)
`define GPIL_TXC_SHIFT_DEG 90
`define GPIL_LINK_QUARTERS (`GPIL_REF_PERIOD_PS / `GPIL_TXC_DELAY_PS)
`define GPIL_QTR_W 2
`define GPIL_QTR_LAST 2'h3
`define GPIL_QTR_TXC_RISE 2'h1
`define GPIL_QTR_TXC_FALL 2'h3

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define GPIL_BYTE_W 8
`define GPIL_NIB_W 4
`define GPIL_PAD_W 10
`define GPIL_SYNC_W 13
`define GPIL_BUF_DEPTH 2
`define GPIL_BUF_CNT_W 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GPIL_PAD_RST 10'h000
`define GPIL_SYNC_RST 13'h0000
`define GPIL_NIB_RST 4'h0
`define GPIL_BYTE_RST 8'h00

`endif

// File: core/gpil_pkg.sv
package gpil_pkg;

  typedef struct packed
  {
    logic [7:0] data;
    logic en;
    logic er;
  } gpil_word_t;

  typedef struct packed
  {
    logic rxc;
    logic [7:0] rxd;
    logic dv;
    logic er;
    logic col;
    logic crs;
  } gpil_pins_t;

  typedef enum logic [1:0]
  {
    GPIL_RX_WAIT_RISE = 2'b01,
    GPIL_RX_WAIT_FALL = 2'b10
  } gpil_rx_state_t;

endpackage

// File: core/gpil_pad_ddr.sv
`timescale 1ns/1ps
`include "gpil_map.svh"

module gpil_pad_ddr
(
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset
  input wire logic load, // Take new rise and fall values
  input wire logic half_next, // Next cycle is the falling half
  input wire logic [`GPIL_PAD_W-1:0] d_rise, // Value for the high half
  input wire logic [`GPIL_PAD_W-1:0] d_fall, // Value for the low half
  output logic [`GPIL_PAD_W-1:0] q // Pad flop output
);

  logic [`GPIL_PAD_W-1:0] rise_r;
  logic [`GPIL_PAD_W-1:0] fall_r;
  logic [`GPIL_PAD_W-1:0] next_rise_r;
  logic [`GPIL_PAD_W-1:0] next_fall_r;
  logic [`GPIL_PAD_W-1:0] next_q;

  always_comb
  begin
    next_rise_r = load ? d_rise : rise_r;
    next_fall_r = load ? d_fall : fall_r;
    next_q = half_next ? next_fall_r : next_rise_r;
  end

  // Last flop before the pin, nothing after it
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rise_r <= `GPIL_PAD_RST;
      fall_r <= `GPIL_PAD_RST;
      q <= `GPIL_PAD_RST;
    end
    else
    begin
      rise_r <= next_rise_r;
      fall_r <= next_fall_r;
      q <= next_q;
    end
  end

endmodule

// File: core/gpil_skid_buf.sv
`timescale 1ns/1ps
`include "gpil_map.svh"

module gpil_skid_buf
  import gpil_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire gpil_word_t in_word, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Sink takes word
  output gpil_word_t out_word // Oldest word
);

  gpil_word_t mem [`GPIL_BUF_DEPTH];
  gpil_word_t next_mem [`GPIL_BUF_DEPTH];
  logic [`GPIL_BUF_CNT_W-1:0] count;
  logic [`GPIL_BUF_CNT_W-1:0] next_count;
  logic wr_ptr;
  logic rd_ptr;
  logic next_wr_ptr;
  logic next_rd_ptr;
  logic do_wr;
  logic do_rd;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_word = mem[rd_ptr];

  always_comb
  begin
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    next_mem = mem;
    if (do_wr)
      next_mem[wr_ptr] = in_word;
    next_wr_ptr = wr_ptr ^ do_wr;
    next_rd_ptr = rd_ptr ^ do_rd;
    next_count = count + {1'b0, do_wr} - {1'b0, do_rd};
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem[0] <= '0;
      mem[1] <= '0;
      count <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end
    else
    begin
      mem <= next_mem;
      count <= next_count;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

endmodule

// File: core/gpil_phy_if.sv
`timescale 1ns/1ps
`include "gpil_map.svh"

module gpil_phy_if
  import gpil_pkg::*;
(
  input wire logic mclk, // System clock, 20 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic rgmii_mode, // 1 selects RGMII, 0 GMII
  input wire logic [7:0] tx_data, // User transmit byte
  input wire logic tx_valid, // User transmit byte valid
  input wire logic tx_error, // User transmit byte errored
  output logic tx_ready, // Transmit byte taken this cycle
  output logic [7:0] pad_txd, // Transmit data pins
  output logic pad_tx_en, // Transmit enable or RGMII control
  output logic pad_tx_er, // Transmit error, GMII only
  output logic pad_txc, // Forwarded transmit clock
  input wire logic pad_rxc, // Receive clock from PHY
  input wire logic [7:0] pad_rxd, // Receive data pins
  input wire logic pad_rx_dv, // Receive valid or RGMII control
  input wire logic pad_rx_er, // Receive error, GMII only
  input wire logic pad_col, // Collision, asynchronous
  input wire logic pad_crs, // Carrier sense, asynchronous
  output logic [7:0] rx_data, // User receive byte
  output logic rx_error, // User receive byte errored
  output logic rx_valid, // User receive byte valid
  input wire logic rx_ready, // User accepts receive byte
  output logic rx_drop, // Received byte lost, buffer full
  output logic rx_active, // Receive frame in progress
  output logic col_sync, // Synchronised collision
  output logic crs_sync // Synchronised carrier sense
);

  // ----------------------------------------------------------------
  // Reference phase divider
  // ----------------------------------------------------------------
  // Each link period is four quarters; one quarter is the 2 ns offset.
  logic [`GPIL_QTR_W-1:0] quarter;
  logic [`GPIL_QTR_W-1:0] next_quarter;

  always_comb
  begin
    next_quarter = quarter + 2'h1;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      quarter <= 2'h0;
    else
      quarter <= next_quarter;
  end

  // ----------------------------------------------------------------
  // Transmit byte intake
  // ----------------------------------------------------------------
  // A byte is taken once per link period; an empty slot sends idle.
  gpil_word_t tx_word;
  logic tx_load;
  logic [`GPIL_PAD_W-1:0] tx_rise;
  logic [`GPIL_PAD_W-1:0] tx_fall;
  logic [`GPIL_PAD_W-1:0] tx_pads;
  logic [`GPIL_NIB_W-1:0] zero_nib;

  assign zero_nib = `GPIL_NIB_RST;
  assign tx_ready = (quarter == `GPIL_QTR_LAST);
  assign tx_load = tx_ready;

  always_comb
  begin
    tx_word.data = tx_valid ? tx_data : `GPIL_BYTE_RST;
    tx_word.en = tx_valid;
    tx_word.er = tx_valid && tx_error;
  end

  // ----------------------------------------------------------------
  // Pad value selection
  // ----------------------------------------------------------------
  // RGMII carries enable on the rise and enable xor error on the fall.
  always_comb
  begin
    if (rgmii_mode)
    begin
      tx_rise = {zero_nib, tx_word.data[3:0], tx_word.en, 1'b0};
      tx_fall = {zero_nib, tx_word.data[7:4], tx_word.en ^ tx_word.er, 1'b0};
    end
    else
    begin
      tx_rise = {tx_word.data, tx_word.en, tx_word.er};
      tx_fall = {tx_word.data, tx_word.en, tx_word.er};
    end
  end

  gpil_pad_ddr u_tx_pads
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(tx_load),
    .half_next(next_quarter[1]),
    .d_rise(tx_rise),
    .d_fall(tx_fall),
    .q(tx_pads)
  );

  // Pins are wired straight from the pad flops
  assign pad_txd = tx_pads[9:2];
  assign pad_tx_en = tx_pads[1];
  assign pad_tx_er = tx_pads[0];

  // ----------------------------------------------------------------
  // Forwarded transmit clock
  // ----------------------------------------------------------------
  // Built from the same divider and one pad flop, so it sees the data's delay.
  logic next_txc;
  logic quad_next;

  always_comb
  begin
    quad_next = (next_quarter >= `GPIL_QTR_TXC_RISE) &&
                (next_quarter < `GPIL_QTR_TXC_FALL);
    if (rgmii_mode)
      next_txc = quad_next;
    else
      next_txc = next_quarter[1];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pad_txc <= 1'b0;
    else
      pad_txc <= next_txc;
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Three synchroniser flops and a filter flop per pin; a change is believed once stages two and three agree.
  gpil_pins_t pins_in;
  logic [`GPIL_SYNC_W-1:0] sync1;
  logic [`GPIL_SYNC_W-1:0] sync2;
  logic [`GPIL_SYNC_W-1:0] sync3;
  logic [`GPIL_SYNC_W-1:0] filt;
  logic [`GPIL_SYNC_W-1:0] next_filt;
  gpil_pins_t pins;

  assign pins_in.rxc = pad_rxc;
  assign pins_in.rxd = pad_rxd;
  assign pins_in.dv = pad_rx_dv;
  assign pins_in.er = pad_rx_er;
  assign pins_in.col = pad_col;
  assign pins_in.crs = pad_crs;

  genvar gi;
  generate
    for (gi = 0; gi < `GPIL_SYNC_W; gi = gi + 1)
    begin : g_filt
      // One driver per bit keeps the filter free of shared process writes
      assign next_filt[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : filt[gi];
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= `GPIL_SYNC_RST;
      sync2 <= `GPIL_SYNC_RST;
      sync3 <= `GPIL_SYNC_RST;
      filt <= `GPIL_SYNC_RST;
    end
    else
    begin
      sync1 <= pins_in;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
    end
  end

  assign pins = filt;
  assign col_sync = pins.col;
  assign crs_sync = pins.crs;

  // ----------------------------------------------------------------
  // Receive clock edges
  // ----------------------------------------------------------------
  // This path belongs to this instance's own PHY clock pin only.
  logic rxc_prev;
  logic rx_rise;
  logic rx_fall;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rxc_prev <= 1'b0;
    else
      rxc_prev <= pins.rxc;
  end

  assign rx_rise = pins.rxc && !rxc_prev;
  assign rx_fall = !pins.rxc && rxc_prev;

  // ----------------------------------------------------------------
  // Receive byte assembly
  // ----------------------------------------------------------------
  gpil_rx_state_t rx_state;
  gpil_rx_state_t next_rx_state;
  logic [`GPIL_NIB_W-1:0] low_nib;
  logic [`GPIL_NIB_W-1:0] next_low_nib;
  logic ctl_rise;
  logic next_ctl_rise;
  logic dv_level;
  logic next_dv_level;
  gpil_word_t rx_word;
  logic rx_push;
  logic buf_in_ready;
  logic next_rx_drop;

  always_comb
  begin
    next_rx_state = rx_state;
    next_low_nib = low_nib;
    next_ctl_rise = ctl_rise;
    next_dv_level = dv_level;
    rx_word.data = pins.rxd;
    rx_word.en = pins.dv;
    rx_word.er = pins.er;
    rx_push = 1'b0;
    if (!rgmii_mode)
    begin
      next_rx_state = GPIL_RX_WAIT_RISE;
      if (rx_rise)
      begin
        rx_push = pins.dv;
        next_dv_level = pins.dv;
      end
    end
    else
    begin
      unique case (rx_state)
        GPIL_RX_WAIT_RISE:
        begin
          if (rx_rise)
          begin
            next_low_nib = pins.rxd[3:0];
            next_ctl_rise = pins.dv;
            next_rx_state = GPIL_RX_WAIT_FALL;
          end
        end
        GPIL_RX_WAIT_FALL:
        begin
          rx_word.data = {pins.rxd[3:0], low_nib};
          rx_word.en = ctl_rise;
          rx_word.er = ctl_rise ^ pins.dv;
          if (rx_fall)
          begin
            rx_push = ctl_rise;
            next_dv_level = ctl_rise;
            next_rx_state = GPIL_RX_WAIT_RISE;
          end
        end
        default:
        begin
          next_rx_state = GPIL_RX_WAIT_RISE;
        end
      endcase
    end
    next_rx_drop = rx_push && !buf_in_ready;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state <= GPIL_RX_WAIT_RISE;
      low_nib <= `GPIL_NIB_RST;
      ctl_rise <= 1'b0;
      dv_level <= 1'b0;
      rx_drop <= 1'b0;
    end
    else
    begin
      rx_state <= next_rx_state;
      low_nib <= next_low_nib;
      ctl_rise <= next_ctl_rise;
      dv_level <= next_dv_level;
      rx_drop <= next_rx_drop;
    end
  end

  assign rx_active = dv_level;

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  // Two entries ride out a short user stall; a longer one drops and flags.
  gpil_word_t rx_out;

  gpil_skid_buf u_rx_buf
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(rx_push),
    .in_ready(buf_in_ready),
    .in_word(rx_word),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_word(rx_out)
  );

  assign rx_data = rx_out.data;
  assign rx_error = rx_out.er;

endmodule

// File: testbench/gpil_phy_model.sv
`timescale 1ns/1ps
module gpil_phy_model
(
  output logic rxc, // Receive clock
  output logic [7:0] rxd, // Receive data
  output logic dv, // Valid or control
  output logic er, // Receive error
  output logic col, // Collision
  output logic crs // Carrier sense
);
  localparam realtime QTR = 137.5;

  initial
  begin
    rxc = 1'b0;
    rxd = 8'h00;
    dv = 1'b0;
    er = 1'b0;
    col = 1'b0;
    crs = 1'b0;
  end

  // ----------------------------------------------------------------
  // One byte per receive clock period
  // ----------------------------------------------------------------
  // Slow enough for the sampled clock path; unused lines keep toggling
  task send(input logic rgm, input logic [7:0] b, input logic e);
    rxd = rgm ? {~rxd[7:4], b[3:0]} : b;
    dv = 1'b1;
    er = rgm ? ~er : e;
    #QTR rxc = 1'b1;
    #QTR rxd = rgm ? {~rxd[7:4], b[7:4]} : b;
    dv = rgm ? ~e : 1'b1;
    #QTR rxc = 1'b0;
    #QTR;
  endtask

  // One quiet clock period ends the frame, then the clock stands still
  task idle();
    dv = 1'b0;
    er = 1'b0;
    rxd = ~rxd;
    #QTR rxc = 1'b1;
    #QTR;
    #QTR rxc = 1'b0;
    #QTR;
  endtask

  task hd(input logic c, input logic s);
    col = c;
    crs = s;
  endtask
endmodule

// File: testbench/gpil_phy_if_props.sv
`timescale 1ns/1ps
module gpil_phy_if_props
(
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset
  input wire logic rgmii_mode, // Variant
  input wire logic [7:0] tx_data, // User byte
  input wire logic tx_valid, // User valid
  input wire logic tx_error, // User error
  input wire logic tx_ready, // Slot
  input wire logic [7:0] pad_txd, // Pins
  input wire logic pad_tx_en, // Enable
  input wire logic pad_tx_er, // Error
  input wire logic pad_txc, // Forwarded clock
  input wire logic pad_col, // Collision pin
  input wire logic col_sync, // Collision out
  input wire logic [7:0] rx_data, // Receive byte
  input wire logic rx_valid, // Receive valid
  input wire logic rx_ready // Receive accept
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence gmii_clk_s;
    !pad_txc [*2] ##1 pad_txc [*2];
  endsequence
  sequence rgmii_clk_s;
    !pad_txc ##1 pad_txc [*2] ##1 !pad_txc;
  endsequence
  sequence slot_s;
    tx_ready && tx_valid;
  endsequence
  sequence gmii_byte_s;
    pad_txd == $past(tx_data) && pad_tx_en && pad_tx_er == $past(tx_error)
      ##1 $stable({pad_txd, pad_tx_en, pad_tx_er}) [*3];
  endsequence
  sequence rgmii_nib_s;
    pad_txd == ($past(tx_data) & 8'h0f) && pad_tx_en
      ##2 pad_txd == ($past(tx_data, 3) >> 4) && pad_tx_en == !$past(tx_error, 3);
  endsequence
  sequence quiet_s;
    pad_txd == 8'h00 && !pad_tx_en && !pad_tx_er;
  endsequence

  slot_period_a: assert property (tx_ready |=> !tx_ready [*3] ##1 tx_ready)
    else $error("slot period wrong");
  gmii_txc_a: assert property (tx_ready && !rgmii_mode |=> gmii_clk_s)
    else $error("gmii clock phase wrong");
  rgmii_txc_a: assert property (tx_ready && rgmii_mode |=> rgmii_clk_s)
    else $error("rgmii clock phase wrong");
  gmii_data_a: assert property (slot_s ##0 !rgmii_mode |=> gmii_byte_s)
    else $error("gmii byte wrong");
  rgmii_nib_a: assert property (slot_s ##0 rgmii_mode |=> rgmii_nib_s)
    else $error("rgmii nibble wrong");
  idle_pins_a: assert property (tx_ready && !tx_valid |=> quiet_s [*4])
    else $error("idle slot not quiet");
  rgmii_no_er_a: assert property (rgmii_mode && $past(rgmii_mode, 2) |-> !pad_tx_er)
    else $error("error pin used in rgmii");
  col_follow_a: assert property (pad_col [*7] |-> col_sync)
    else $error("collision not synchronised");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("receive word not held");
endmodule

bind gpil_phy_if gpil_phy_if_props i_gpil_phy_if_props (.mclk, .rst_n, .rgmii_mode, .tx_data,
  .tx_valid, .tx_error, .tx_ready, .pad_txd, .pad_tx_en, .pad_tx_er, .pad_txc, .pad_col,
  .col_sync, .rx_data, .rx_valid, .rx_ready);

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic mclk, rst_n, rgmii_mode, tx_valid, tx_error, tx_ready, rx_ready;
  logic [7:0] tx_data, pad_txd, pad_rxd, rx_data;
  logic pad_tx_en, pad_tx_er, pad_txc, pad_rxc, pad_rx_dv, pad_rx_er, pad_col, pad_crs;
  logic rx_error, rx_valid, rx_drop, rx_active, col_sync, crs_sync;
  int failures, n_checks, drops;

  gpil_phy_if i_gpil_phy_if (.mclk, .rst_n, .rgmii_mode, .tx_data, .tx_valid, .tx_error,
    .tx_ready, .pad_txd, .pad_tx_en, .pad_tx_er, .pad_txc, .pad_rxc, .pad_rxd, .pad_rx_dv,
    .pad_rx_er, .pad_col, .pad_crs, .rx_data, .rx_error, .rx_valid, .rx_ready, .rx_drop,
    .rx_active, .col_sync, .crs_sync);
  gpil_phy_model i_gpil_phy_model (.rxc(pad_rxc), .rxd(pad_rxd), .dv(pad_rx_dv),
    .er(pad_rx_er), .col(pad_col), .crs(pad_crs));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Counted mid-cycle, away from the edge that launches the pulse
  always @(negedge mclk)
    if (rx_drop === 1'b1)
      drops++;

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bounded wait at falling edges: 0 for the transmit slot, 1 for receive data
  task wait_hi(input int sel);
    int n;
    n = 0;
    while ((sel ? rx_valid : tx_ready) !== 1'b1)
    begin
      @(negedge mclk);
      n++;
      if (n > 40)
      begin
        chk("handshake", 16'h0001, 16'h0000);
        results();
      end
    end
  endtask

  task do_reset(input logic rgm);
    rst_n = 1'b0;
    rgmii_mode = rgm;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Byte is held until its slot; the next call may follow in the same slot
  task tx_byte(input logic [7:0] d, input logic e, input logic v);
    logic [10:0] exp;
    tx_data = d;
    tx_error = e;
    tx_valid = v;
    wait_hi(0);
    for (int q = 0; q < 4; q++)
    begin
      @(negedge mclk);
      if (rgmii_mode)
        exp = {(q < 2 ? d & 8'h0f : d >> 4) & {8{v}}, v ^ (v & e & (q > 1)), 1'b0,
          q == 1 || q == 2};
      else
        exp = {d & {8{v}}, v, v & e, q > 1};
      chk("tx pads", 16'(exp), {5'h00, pad_txd, pad_tx_en, pad_tx_er, pad_txc});
    end
  endtask

  // Third byte meets a full buffer and is lost
  task rx_burst(input logic rgm);
    int d0;
    d0 = drops;
    rx_ready = 1'b0;
    i_gpil_phy_model.send(rgm, 8'h3c, 1'b0);
    i_gpil_phy_model.send(rgm, 8'hc3, 1'b1);
    i_gpil_phy_model.send(rgm, 8'h96, 1'b0);
    repeat (3) @(negedge mclk);
    chk("rx active", 16'h0001, {15'h0000, rx_active});
    i_gpil_phy_model.idle();
    repeat (8) @(negedge mclk);
    chk("rx drops", 16'h0001, 16'(drops - d0));
    chk("rx ended", 16'h0000, {15'h0000, rx_active});
    for (int i = 0; i < 2; i++)
    begin
      wait_hi(1);
      chk("rx byte", i ? 16'h01c3 : 16'h003c, {7'h00, rx_error, rx_data});
      rx_ready = 1'b1;
      @(negedge mclk);
      rx_ready = 1'b0;
    end
    @(negedge mclk);
    chk("rx empty", 16'h0000, {15'h0000, rx_valid});
  endtask

  task hd_check(input logic c, input logic s);
    i_gpil_phy_model.hd(c, s);
    repeat (8) @(negedge mclk);
    chk("col crs", {14'h0000, c, s}, {14'h0000, col_sync, crs_sync});
  endtask

  initial
  begin
    failures = 0;
    n_checks = 0;
    drops = 0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    tx_error = 1'b0;
    rx_ready = 1'b0;
    for (int m = 0; m < 2; m++)
    begin
      do_reset(m[0]);
      tx_byte(8'h00, 1'b0, 1'b0);
      tx_byte(8'h77, 1'b1, 1'b0);
      tx_byte(8'ha5, 1'b0, 1'b1);
      tx_byte(8'h5a, 1'b1, 1'b1);
      tx_byte(8'h00, 1'b0, 1'b0);
      rx_burst(m[0]);
      hd_check(1'b1, 1'b0);
      hd_check(1'b0, 1'b1);
    end
    results();
  end
endmodule
